// >>> hw/jtp_map.vh
// constants for the test access port controller
`ifndef JTP_MAP_VH
`define JTP_MAP_VH

`define JTP_ST_W 4
`define JTP_ST_TLR 4'h0
`define JTP_ST_RTI 4'h1
`define JTP_ST_SEL_DR 4'h2
`define JTP_ST_CAP_DR 4'h3
`define JTP_ST_SHF_DR 4'h4
`define JTP_ST_EX1_DR 4'h5
`define JTP_ST_PAU_DR 4'h6
`define JTP_ST_EX2_DR 4'h7
`define JTP_ST_UPD_DR 4'h8
`define JTP_ST_SEL_IR 4'h9
`define JTP_ST_CAP_IR 4'hA
`define JTP_ST_SHF_IR 4'hB
`define JTP_ST_EX1_IR 4'hC
`define JTP_ST_PAU_IR 4'hD
`define JTP_ST_EX2_IR 4'hE
`define JTP_ST_UPD_IR 4'hF

`define JTP_IR_W 4
`define JTP_IR_CAPTURE 4'h1
`define JTP_INSTR_USER_DR 4'h2
`define JTP_INSTR_BYPASS 4'hF
`define JTP_INSTR_RESET 4'hF

`define JTP_DR_W 8
`define JTP_DR_RESET 8'h00

`endif

// >>> hw/jtp_shift_reg.v
// capture, shift and update register for one serial path
`timescale 1ns/1ps
`default_nettype none

module jtp_shift_reg #(
    parameter W = 8,
    parameter [W-1:0] RESET_VAL = {W{1'b0}}
)(
    input wire clock,
    input wire reset_n,
    input wire clear,
    input wire capture_en,
    input wire shift_en,
    input wire update_en,
    input wire [W-1:0] capture_val,
    input wire serial_in,
    output wire serial_out,
    output reg [W-1:0] par_q
);

reg [W-1:0] sr_q;

assign serial_out = sr_q[0];

always @(posedge clock or negedge reset_n)
begin
    if (!reset_n)
    begin
        sr_q <= {W{1'b0}};
        par_q <= RESET_VAL;
    end
    else
    begin
        if (capture_en)
            sr_q <= capture_val;
        else if (shift_en)
            sr_q <= {serial_in, sr_q[W-1:1]};
        if (clear)
            par_q <= RESET_VAL;
        else if (update_en)
            par_q <= sr_q;
    end
end

endmodule
`default_nettype wire

// >>> hw/jtp_tap_ctrl.v
// test access port controller sampled from the system clock
// Notes on behaviour
// - state changes, capture and shift follow test clock rising edges; update and data output follow falling edges
// - no dedicated test reset pin; only clock, mode-select, data in and out
// - fuse unprogrammed: pins are ordinary port pins, controller held in reset
// - fuse programmed, disable bit clear: port enabled, input pull-ups on
// - data output undriven in every state that is not shifting, except Exit1 up to its falling edge
// - sixteen-state machine steered by mode-select at each rising edge
// - after power-on reset the controller sits in Test-Logic-Reset
// - every shift register moves its least significant bit first
// - four-bit instructions; last bit shifts as mode-select rises to leave
// - instruction capture value 0x01 shifts out while instruction shifts in
// - current instruction selects the data register placed in the serial path
// - mode-select 1,1,0 returns to idle; instruction latched in Update-IR
// - exit and pause states of both branches do nothing
// - data shift keeps mode-select low except for the final bit
// - parallel inputs captured in Capture-DR shift out while new data shifts in
// - latched data register outputs update in Update-DR
// - five test clocks with mode-select high reach Test-Logic-Reset
`timescale 1ns/1ps
`default_nettype none
`include "jtp_map.vh"

module jtp_tap_ctrl #(
    parameter DR_W = `JTP_DR_W
)(
    input wire clock,
    input wire reset_n,
    input wire test_port_enable_fuse,
    input wire test_port_disable_bit,
    input wire tck_pin,
    input wire tms_pin,
    input wire tdi_pin,
    input wire [DR_W-1:0] dr_capture_in,
    output reg tdo_out_q,
    output reg tdo_oe_q,
    output reg port_enabled_q,
    output reg pullup_en_q,
    output reg [`JTP_ST_W-1:0] tap_state_q,
    output reg [`JTP_IR_W-1:0] instr_out_q,
    output reg [DR_W-1:0] dr_out_q
);

// state codes; plain binary so all sixteen fit the 4-bit state port
localparam [`JTP_ST_W-1:0] ST_TLR = `JTP_ST_TLR;
localparam [`JTP_ST_W-1:0] ST_RTI = `JTP_ST_RTI;
localparam [`JTP_ST_W-1:0] ST_SEL_DR = `JTP_ST_SEL_DR;
localparam [`JTP_ST_W-1:0] ST_CAP_DR = `JTP_ST_CAP_DR;
localparam [`JTP_ST_W-1:0] ST_SHF_DR = `JTP_ST_SHF_DR;
localparam [`JTP_ST_W-1:0] ST_EX1_DR = `JTP_ST_EX1_DR;
localparam [`JTP_ST_W-1:0] ST_PAU_DR = `JTP_ST_PAU_DR;
localparam [`JTP_ST_W-1:0] ST_EX2_DR = `JTP_ST_EX2_DR;
localparam [`JTP_ST_W-1:0] ST_UPD_DR = `JTP_ST_UPD_DR;
localparam [`JTP_ST_W-1:0] ST_SEL_IR = `JTP_ST_SEL_IR;
localparam [`JTP_ST_W-1:0] ST_CAP_IR = `JTP_ST_CAP_IR;
localparam [`JTP_ST_W-1:0] ST_SHF_IR = `JTP_ST_SHF_IR;
localparam [`JTP_ST_W-1:0] ST_EX1_IR = `JTP_ST_EX1_IR;
localparam [`JTP_ST_W-1:0] ST_PAU_IR = `JTP_ST_PAU_IR;
localparam [`JTP_ST_W-1:0] ST_EX2_IR = `JTP_ST_EX2_IR;
localparam [`JTP_ST_W-1:0] ST_UPD_IR = `JTP_ST_UPD_IR;

// transitions of the standard diagram
function [`JTP_ST_W-1:0] next_state;
    input [`JTP_ST_W-1:0] st;
    input tms;
    begin
        case (st)
            ST_TLR:
                if (tms)
                    next_state = ST_TLR;
                else
                    next_state = ST_RTI;
            ST_RTI:
                if (tms)
                    next_state = ST_SEL_DR;
                else
                    next_state = ST_RTI;
            ST_SEL_DR:
                if (tms)
                    next_state = ST_SEL_IR;
                else
                    next_state = ST_CAP_DR;
            ST_CAP_DR:
                if (tms)
                    next_state = ST_EX1_DR;
                else
                    next_state = ST_SHF_DR;
            ST_SHF_DR:
                if (tms)
                    next_state = ST_EX1_DR;
                else
                    next_state = ST_SHF_DR;
            ST_EX1_DR:
                if (tms)
                    next_state = ST_UPD_DR;
                else
                    next_state = ST_PAU_DR;
            ST_PAU_DR:
                if (tms)
                    next_state = ST_EX2_DR;
                else
                    next_state = ST_PAU_DR;
            ST_EX2_DR:
                if (tms)
                    next_state = ST_UPD_DR;
                else
                    next_state = ST_SHF_DR;
            ST_UPD_DR:
                if (tms)
                    next_state = ST_SEL_DR;
                else
                    next_state = ST_RTI;
            ST_SEL_IR:
                if (tms)
                    next_state = ST_TLR;
                else
                    next_state = ST_CAP_IR;
            ST_CAP_IR:
                if (tms)
                    next_state = ST_EX1_IR;
                else
                    next_state = ST_SHF_IR;
            ST_SHF_IR:
                if (tms)
                    next_state = ST_EX1_IR;
                else
                    next_state = ST_SHF_IR;
            ST_EX1_IR:
                if (tms)
                    next_state = ST_UPD_IR;
                else
                    next_state = ST_PAU_IR;
            ST_PAU_IR:
                if (tms)
                    next_state = ST_EX2_IR;
                else
                    next_state = ST_PAU_IR;
            ST_EX2_IR:
                if (tms)
                    next_state = ST_UPD_IR;
                else
                    next_state = ST_SHF_IR;
            ST_UPD_IR:
                if (tms)
                    next_state = ST_SEL_DR;
                else
                    next_state = ST_RTI;
            default:
                next_state = ST_TLR;
        endcase
    end
endfunction

// pin synchronisers; first stage feeds only the second
// limitation: each test clock phase must last longer than one system clock period,
// otherwise a short pulse can fall between two samples of the first stage
// idle levels: data in and mode-select pulled high, test clock low
localparam [2:0] SYNC_IDLE = 3'h6;
wire [2:0] pin_raw = {tdi_pin, tms_pin, tck_pin};
wire [2:0] pin_s;
reg tck_last_q;
wire tck_rise;
wire tck_fall;
wire tms_s;
wire tdi_s;

genvar gi;
generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_sync
        reg [1:0] stage_q;
        always @(posedge clock or negedge reset_n)
        begin
            if (!reset_n)
                stage_q <= {2{SYNC_IDLE[gi]}};
            else
                stage_q <= {stage_q[0], pin_raw[gi]};
        end
        assign pin_s[gi] = stage_q[1];
    end
endgenerate

always @(posedge clock or negedge reset_n)
begin
    if (!reset_n)
        tck_last_q <= 1'b0;
    else
        tck_last_q <= pin_s[0];
end

assign tck_rise = pin_s[0] & ~tck_last_q;
assign tck_fall = ~pin_s[0] & tck_last_q;
assign tms_s = pin_s[1];
assign tdi_s = pin_s[2];

// no test reset pin: apart from system reset, only the fuse and disable bit can force reset
wire port_on = test_port_enable_fuse & ~test_port_disable_bit;

wire [`JTP_ST_W-1:0] state_d = next_state(tap_state_q, tms_s);

always @(posedge clock or negedge reset_n)
begin
    if (!reset_n)
        tap_state_q <= `JTP_ST_TLR;
    else if (!port_on)
        tap_state_q <= `JTP_ST_TLR;
    else if (tck_rise)
        tap_state_q <= state_d;
end

always @(posedge clock or negedge reset_n)
begin
    if (!reset_n)
    begin
        port_enabled_q <= 1'b0;
        pullup_en_q <= 1'b0;
    end
    else
    begin
        port_enabled_q <= port_on;
        pullup_en_q <= port_on;
    end
end

// pause and exit states assert none of these, so they do nothing
wire in_tlr = (tap_state_q == `JTP_ST_TLR);
wire shf_ir = (tap_state_q == `JTP_ST_SHF_IR);
wire shf_dr = (tap_state_q == `JTP_ST_SHF_DR);
wire cap_ir = tck_rise & (tap_state_q == `JTP_ST_CAP_IR);
wire cap_dr = tck_rise & (tap_state_q == `JTP_ST_CAP_DR);
wire upd_ir = tck_fall & (tap_state_q == `JTP_ST_UPD_IR);
wire upd_dr = tck_fall & (tap_state_q == `JTP_ST_UPD_DR);

// instruction chosen path
wire [`JTP_IR_W-1:0] instr;
wire sel_user = (instr == `JTP_INSTR_USER_DR);

wire ir_sout;
wire dr_sout;
wire [DR_W-1:0] dr_par;

jtp_shift_reg #(
    .W(`JTP_IR_W),
    .RESET_VAL(`JTP_INSTR_RESET)
) u_ir (
    .clock(clock),
    .reset_n(reset_n),
    .clear(in_tlr),
    .capture_en(cap_ir),
    .shift_en(tck_rise & shf_ir),
    .update_en(upd_ir),
    .capture_val(`JTP_IR_CAPTURE),
    .serial_in(tdi_s),
    .serial_out(ir_sout),
    .par_q(instr)
);

jtp_shift_reg #(
    .W(DR_W),
    .RESET_VAL(`JTP_DR_RESET)
) u_dr (
    .clock(clock),
    .reset_n(reset_n),
    .clear(in_tlr),
    .capture_en(cap_dr & sel_user),
    .shift_en(tck_rise & shf_dr & sel_user),
    .update_en(upd_dr & sel_user),
    .capture_val(dr_capture_in),
    .serial_in(tdi_s),
    .serial_out(dr_sout),
    .par_q(dr_par)
);

// one-bit bypass path for every other instruction
reg bypass_q;

always @(posedge clock or negedge reset_n)
begin
    if (!reset_n)
        bypass_q <= 1'b0;
    else if (cap_dr & ~sel_user)
        bypass_q <= 1'b0;
    else if (tck_rise & shf_dr & ~sel_user)
        bypass_q <= tdi_s;
end

always @(posedge clock or negedge reset_n)
begin
    if (!reset_n)
    begin
        instr_out_q <= `JTP_INSTR_RESET;
        dr_out_q <= `JTP_DR_RESET;
    end
    else
    begin
        instr_out_q <= instr;
        dr_out_q <= dr_par;
    end
end

// output changes on the falling test clock so the far end samples a settled bit
reg tdo_out_d;
reg tdo_oe_d;

always @*
begin
    tdo_out_d = tdo_out_q;
    tdo_oe_d = tdo_oe_q;
    if (!port_on)
    begin
        tdo_out_d = 1'b0;
        tdo_oe_d = 1'b0;
    end
    else if (tck_fall)
    begin
        tdo_oe_d = shf_ir | shf_dr;
        if (shf_ir)
            tdo_out_d = ir_sout;
        else if (sel_user)
            tdo_out_d = dr_sout;
        else
            tdo_out_d = bypass_q;
    end
end

always @(posedge clock or negedge reset_n)
begin
    if (!reset_n)
    begin
        tdo_out_q <= 1'b0;
        tdo_oe_q <= 1'b0;
    end
    else
    begin
        tdo_out_q <= tdo_out_d;
        tdo_oe_q <= tdo_oe_d;
    end
end

endmodule
`default_nettype wire

// >>> sim/jtp_host.sv
// behavioural test controller driving the port pins
`timescale 1ns/1ps
`default_nettype none
module jtp_host (
    input wire logic clock,
    input wire logic sys_reset_n,
    input wire logic tdo_line,
    output logic tck,
    output logic tms,
    output logic tdi
);
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // one 320 ns period; tdo read late in the high phase, where it is settled
    task automatic cyc(input logic m, input logic d, output logic q);
    begin
        while (!sys_reset_n)
            @(posedge clock);
        @(posedge clock);
        #2;
        tck = 1'b0;
        tms = m;
        tdi = d;
        repeat (4) @(posedge clock);
        #2;
        tck = 1'b1;
        repeat (3) @(posedge clock);
        q = tdo_line;
    end
    endtask
endmodule
`default_nettype wire

// >>> sim/jtp_tap_checker.sv
// concurrent checks on the test access port controller ports
`timescale 1ns/1ps
`default_nettype none
`include "jtp_map.vh"
module jtp_tap_checker #(parameter DR_W = 8) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic test_port_enable_fuse,
    input wire logic test_port_disable_bit,
    input wire logic tdo_oe_q,
    input wire logic port_enabled_q,
    input wire logic pullup_en_q,
    input wire logic [`JTP_ST_W-1:0] tap_state_q,
    input wire logic [`JTP_IR_W-1:0] instr_out_q,
    input wire logic [DR_W-1:0] dr_out_q
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    sequence in_tlr;
        tap_state_q == `JTP_ST_TLR;
    endsequence
    sequence left_idle;
        $changed(tap_state_q) && $past(tap_state_q) == `JTP_ST_RTI;
    endsequence
    chk_gate_hold: assert property ((!test_port_enable_fuse || test_port_disable_bit) [*2] |-> in_tlr)
        else $error("controller left reset while gated");
    chk_port_follow: assert property ($past(reset_n) |->
        port_enabled_q == $past(test_port_enable_fuse && !test_port_disable_bit))
        else $error("port enable does not follow fuse");
    chk_pullup_pair: assert property (pullup_en_q == port_enabled_q)
        else $error("pull-ups differ from port enable");
    chk_oe_shift: assert property (tdo_oe_q |-> tap_state_q inside {`JTP_ST_SHF_IR, `JTP_ST_SHF_DR,
        `JTP_ST_EX1_IR, `JTP_ST_EX1_DR})
        else $error("data out driven outside shifting");
    chk_oe_on: assert property ((tap_state_q == `JTP_ST_SHF_DR) [*8] |-> tdo_oe_q)
        else $error("data out not driven while shifting");
    chk_instr_hold: assert property ($changed(instr_out_q) |->
        ($past(tap_state_q) inside {`JTP_ST_UPD_IR, `JTP_ST_TLR}) || (tap_state_q == `JTP_ST_TLR))
        else $error("instruction changed outside update");
    chk_dr_hold: assert property ($changed(dr_out_q) |->
        ($past(tap_state_q) inside {`JTP_ST_UPD_DR, `JTP_ST_TLR}) || (tap_state_q == `JTP_ST_TLR))
        else $error("data output changed outside update");
    chk_tlr_clear: assert property (in_tlr [*3] |-> instr_out_q == `JTP_INSTR_RESET && dr_out_q == 0)
        else $error("reset state did not clear outputs");
    chk_idle_exit: assert property (left_idle |-> tap_state_q inside {`JTP_ST_SEL_DR, `JTP_ST_TLR})
        else $error("illegal step out of idle");
endmodule
bind jtp_tap_ctrl jtp_tap_checker #(.DR_W(DR_W)) u_chk (
    .clock(clock),
    .reset_n(reset_n),
    .test_port_enable_fuse(test_port_enable_fuse),
    .test_port_disable_bit(test_port_disable_bit),
    .tdo_oe_q(tdo_oe_q),
    .port_enabled_q(port_enabled_q),
    .pullup_en_q(pullup_en_q),
    .tap_state_q(tap_state_q),
    .instr_out_q(instr_out_q),
    .dr_out_q(dr_out_q)
);
`default_nettype wire

// >>> sim/testbench.sv
// self-checking bench for the test access port controller
`timescale 1ns/1ps
`default_nettype none
`include "jtp_map.vh"
module testbench;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic fuse = 1'b0;
    logic dis = 1'b0;
    logic [7:0] cap = 8'h00;
    logic q;
    logic [7:0] got;
    integer failures = 0;
    integer samples_checked = 0;
    wire tck, tms, tdi, tdo_out_q, tdo_oe_q, port_enabled_q, pullup_en_q;
    wire [3:0] tap_state_q, instr_out_q;
    wire [7:0] dr_out_q;
    // external pull-up holds the line high when released
    wire tdo_line = tdo_oe_q ? tdo_out_q : 1'b1;
    always #20 clock = ~clock;
    jtp_tap_ctrl #(.DR_W(8)) u_dut (
        .clock(clock),
        .reset_n(reset_n),
        .test_port_enable_fuse(fuse),
        .test_port_disable_bit(dis),
        .tck_pin(tck),
        .tms_pin(tms),
        .tdi_pin(tdi),
        .dr_capture_in(cap),
        .tdo_out_q(tdo_out_q),
        .tdo_oe_q(tdo_oe_q),
        .port_enabled_q(port_enabled_q),
        .pullup_en_q(pullup_en_q),
        .tap_state_q(tap_state_q),
        .instr_out_q(instr_out_q),
        .dr_out_q(dr_out_q)
    );
    jtp_host u_host (.clock(clock), .sys_reset_n(reset_n), .tdo_line(tdo_line),
        .tck(tck), .tms(tms), .tdi(tdi));
    task automatic print_verdict;
    begin
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
    begin
        samples_checked = samples_checked + 1;
        if (g !== e)
        begin
            failures = failures + 1;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    end
    endtask
    // tms bits applied lsb first, then room for the state to settle
    task automatic move(input logic [7:0] m, input integer n);
        integer i;
    begin
        for (i = 0; i < n; i++)
            u_host.cyc(m[i], 1'b0, q);
        repeat (2) @(posedge clock);
    end
    endtask
    task automatic shift(input logic [7:0] d, input integer n);
        integer i;
    begin
        for (i = 0; i < n; i++)
        begin
            u_host.cyc(i == n - 1, d[i], q);
            got[i] = q;
        end
    end
    endtask
    task automatic t_gate;
    begin
        move(8'h00, 3);
        chk(tap_state_q, `JTP_ST_TLR);
        chk(port_enabled_q, 8'h00);
        @(posedge clock);
        #2;
        fuse = 1'b1;
        dis = 1'b1;
        move(8'h00, 3);
        chk(tap_state_q, `JTP_ST_TLR);
        #2;
        dis = 1'b0;
        repeat (3) @(posedge clock);
        chk({port_enabled_q, pullup_en_q}, 8'h03);
        chk(instr_out_q, `JTP_INSTR_RESET);
    end
    endtask
    task automatic t_ir(input logic [3:0] ins);
    begin
        move(8'h00, 1);
        chk(tap_state_q, `JTP_ST_RTI);
        move(8'h03, 4);
        chk(tap_state_q, `JTP_ST_SHF_IR);
        shift({4'h0, ins}, 4);
        chk(got[3:0], `JTP_IR_CAPTURE);
        move(8'h01, 2);
        chk({tap_state_q, instr_out_q}, {`JTP_ST_RTI, ins});
    end
    endtask
    task automatic t_dr(input logic [7:0] din, input logic [7:0] eout, input logic [7:0] prev, input logic user);
    begin
        move(8'h01, 3);
        chk(tap_state_q, `JTP_ST_SHF_DR);
        shift(din, 8);
        chk(got, eout);
        move(8'h00, 1);
        chk({tdo_oe_q, tap_state_q}, {1'b0, `JTP_ST_PAU_DR});
        chk(dr_out_q, prev);
        move(8'h03, 3);
        chk(tap_state_q, `JTP_ST_RTI);
        chk(dr_out_q, user ? din : prev);
    end
    endtask
    task automatic t_five;
    begin
        move(8'h01, 3);
        move(8'h1F, 5);
        chk(tap_state_q, `JTP_ST_TLR);
        repeat (4) @(posedge clock);
        chk(instr_out_q, `JTP_INSTR_RESET);
        chk(dr_out_q, `JTP_DR_RESET);
    end
    endtask
    initial
    begin
        #200000;
        failures = failures + 1;
        print_verdict;
    end
    initial
    begin
        repeat (10) @(posedge clock);
        #2;
        reset_n = 1'b1;
        t_gate;
        cap = 8'hA5;
        t_ir(`JTP_INSTR_USER_DR);
        t_dr(8'h3C, 8'hA5, 8'h00, 1'b1);
        t_ir(`JTP_INSTR_BYPASS);
        t_dr(8'h5A, 8'hB4, 8'h3C, 1'b0);
        t_five;
        print_verdict;
    end
endmodule
`default_nettype wire
